// ---- src/crs_pkg.sv ----
// crs_pkg: constants and types for the cpu register set and flags block
// assumes a single 32-bit ahb-lite slave with word-aligned registers
package crs_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_GEN0 = 8'h00;
	localparam logic [7:0] OFF_SEG0 = 8'h20;
	localparam logic [7:0] OFF_IP = 8'h30;
	localparam logic [7:0] OFF_FLAGS = 8'h34;
	localparam logic [7:0] OFF_OP = 8'h38;
	localparam logic [7:0] OFF_RES = 8'h3C;
	localparam logic [7:0] OFF_CTRL = 8'h40;
	localparam logic [7:0] OFF_ADDR = 8'h44;
	localparam logic [7:0] OFF_STEP = 8'h48;
	localparam logic [7:0] OFF_BYTE = 8'h4C;

	// flag bit positions
	localparam int CARRY_POS = 0;
	localparam int PARITY_POS = 2;
	localparam int NIBBLE_POS = 4;
	localparam int ZERO_POS = 6;
	localparam int SIGN_POS = 7;
	localparam int STEP_POS = 8;
	localparam int IEN_POS = 9;
	localparam int DIR_POS = 10;
	localparam int OVF_POS = 11;

	// result and control flag masks, the value of unassigned bits and reset values
	localparam logic [15:0] RESULT_MASK = 16'h08D5;
	localparam logic [15:0] CONTROL_MASK = 16'h0700;
	localparam logic [15:0] FIXED_ONES = 16'hF002;
	localparam logic [15:0] FLAGS_RST = 16'hF002;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// operation command field layout
	localparam int OP_CODE_LSB = 0;
	localparam int OP_DST_LSB = 4;
	localparam int OP_SRC_LSB = 8;
	localparam int OP_BYTE_POS = 12;

	// control command bits
	localparam int CTRL_STEP_POS = 0;
	localparam int CTRL_ADV_POS = 4;
	localparam int CTRL_STR_POS = 8;
	localparam int CTRL_INT_POS = 12;

	// segment shift and address forming
	localparam int SEG_SHIFT = 4;
	localparam int PHYS_W = 20;

	typedef enum logic [2:0] {
		CRS_ADD = 3'h0,
		CRS_ADC = 3'h1,
		CRS_SUB = 3'h2,
		CRS_SBB = 3'h3,
		CRS_AND = 3'h4,
		CRS_OR = 3'h5,
		CRS_XOR = 3'h6,
		CRS_MOV = 3'h7
	} crs_op_t;

endpackage

// ---- src/crs_regset.sv ----
// crs_regset: register set, flags word, address forming and clock divide
// assumes an ahb-lite master on hclk; one slave, hready from hreadyout
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module crs_regset #(
	parameter int ADDR_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic int_req,
	output logic int_taken,
	output logic step_trap,
	output logic proc_clk
);

	typedef struct packed {
		logic [7:0][15:0] gen;
		logic [3:0][15:0] seg;
		logic [15:0] ip;
		logic [15:0] flags;
		logic [15:0] result;
		logic [15:0] str_index;
		logic [19:0] phys;
		logic step_pend;
		logic int_taken;
		logic step_trap;
		logic proc_clk;
		logic dph_wr;
		logic dph_rd;
		logic [7:0] dph_addr;
		logic [31:0] rdata;
		logic int_s1;
		logic int_s2;
	} crs_state_t;

	crs_state_t st_r;
	crs_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// datapath helpers

	function automatic logic [15:0] rd_opnd(input crs_state_t s,
		input logic [2:0] idx, input logic byte_op);
		logic [15:0] v;
		v = 16'h0000;
		if (byte_op) begin
			// 0..3 low halves, 4..7 high halves of the first four
			v = idx[2] ? {8'h00, s.gen[idx[1:0]][15:8]} :
				{8'h00, s.gen[idx[1:0]][7:0]};
		end else begin
			v = s.gen[idx];
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [2:0] opc;
		logic [2:0] dsel;
		logic [2:0] ssel;
		logic byte_op;
		logic [15:0] a;
		logic [15:0] b;
		logic cin;
		logic [16:0] sum;
		logic [15:0] res;
		logic msb_a;
		logic msb_b;
		logic msb_r;
		logic cy;
		logic ov;
		logic sub;
		logic [4:0] nib;
		logic [15:0] f;
		logic [15:0] wd;
		logic [7:0] da;
		logic [1:0] ssg;
		logic [15:0] off;
		logic [2:0] bsel;
		opc = 3'h0;
		dsel = 3'h0;
		ssel = 3'h0;
		byte_op = 1'b0;
		a = 16'h0000;
		b = 16'h0000;
		cin = 1'b0;
		sum = 17'h00000;
		res = 16'h0000;
		msb_a = 1'b0;
		msb_b = 1'b0;
		msb_r = 1'b0;
		cy = 1'b0;
		ov = 1'b0;
		sub = 1'b0;
		nib = 5'h00;
		f = 16'h0000;
		wd = hwdata[15:0];
		da = st_r.dph_addr;
		ssg = 2'h0;
		off = 16'h0000;
		bsel = 3'h0;
		st_nxt = st_r;
		st_nxt.int_taken = 1'b0;
		st_nxt.step_trap = 1'b0;
		// a pending step lives one cycle; a fresh request in that cycle wins
		st_nxt.step_pend = 1'b0;
		st_nxt.proc_clk = ~st_r.proc_clk;
		st_nxt.int_s1 = int_req;
		st_nxt.int_s2 = st_r.int_s1;

		// address phase capture
		st_nxt.dph_wr = hsel && hready && htrans[1] && hwrite;
		st_nxt.dph_rd = hsel && hready && htrans[1] && !hwrite;
		st_nxt.dph_addr = haddr[7:0];

		// maskable interrupt gate
		if (st_r.int_s2 && st_r.flags[crs_pkg::IEN_POS]) begin
			st_nxt.int_taken = 1'b1;
			st_nxt.flags[crs_pkg::IEN_POS] = 1'b0;
		end

		if (st_r.dph_wr) begin
			if (da < crs_pkg::OFF_SEG0) begin
				st_nxt.gen[da[4:2]] = wd;
			end else if (da < crs_pkg::OFF_IP) begin
				st_nxt.seg[da[3:2]] = wd;
			end else if (da == crs_pkg::OFF_IP) begin
				st_nxt.ip = wd;
			end else if (da == crs_pkg::OFF_FLAGS) begin
				st_nxt.flags = (wd & (crs_pkg::RESULT_MASK |
					crs_pkg::CONTROL_MASK)) | crs_pkg::FIXED_ONES;
			end else if (da == crs_pkg::OFF_BYTE) begin
				// byte half write: [2:0] select, [15:8] value
				bsel = wd[2:0];
				if (bsel[2]) begin
					st_nxt.gen[bsel[1:0]][15:8] = wd[15:8];
				end else begin
					st_nxt.gen[bsel[1:0]][7:0] = wd[15:8];
				end
			end else if (da == crs_pkg::OFF_OP) begin
				opc = wd[crs_pkg::OP_CODE_LSB +: 3];
				dsel = wd[crs_pkg::OP_DST_LSB +: 3];
				ssel = wd[crs_pkg::OP_SRC_LSB +: 3];
				byte_op = wd[crs_pkg::OP_BYTE_POS];
				a = rd_opnd(st_r, dsel, byte_op);
				b = rd_opnd(st_r, ssel, byte_op);
				sub = (opc == crs_pkg::CRS_SUB) || (opc == crs_pkg::CRS_SBB);
				cin = ((opc == crs_pkg::CRS_ADC) || (opc == crs_pkg::CRS_SBB))
					&& st_r.flags[crs_pkg::CARRY_POS];
				unique case (opc)
					crs_pkg::CRS_ADD, crs_pkg::CRS_ADC: begin
						sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
					end
					crs_pkg::CRS_SUB, crs_pkg::CRS_SBB: begin
						sum = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
					end
					crs_pkg::CRS_AND: sum = {1'b0, a & b};
					crs_pkg::CRS_OR: sum = {1'b0, a | b};
					crs_pkg::CRS_XOR: sum = {1'b0, a ^ b};
					crs_pkg::CRS_MOV: sum = {1'b0, b};
				endcase
				res = byte_op ? {8'h00, sum[7:0]} : sum[15:0];
				msb_a = byte_op ? a[7] : a[15];
				msb_b = byte_op ? b[7] : b[15];
				msb_r = byte_op ? res[7] : res[15];
				cy = byte_op ? sum[8] : sum[16];
				nib = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
					: ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
				ov = sub ? ((msb_a != msb_b) && (msb_r != msb_a))
					: ((msb_a == msb_b) && (msb_r != msb_a));
				if (opc > crs_pkg::CRS_SBB) begin
					cy = 1'b0;
					ov = 1'b0;
					nib = 5'h00;
				end
				f = st_r.flags;
				f[crs_pkg::CARRY_POS] = cy;
				f[crs_pkg::PARITY_POS] = ~^res[7:0];
				f[crs_pkg::NIBBLE_POS] = nib[4];
				f[crs_pkg::ZERO_POS] = (res == 16'h0000);
				f[crs_pkg::SIGN_POS] = msb_r;
				f[crs_pkg::OVF_POS] = ov;
				// control bits kept, only result flags replaced
				st_nxt.flags = (f & crs_pkg::RESULT_MASK) |
					(st_r.flags & ~crs_pkg::RESULT_MASK);
				st_nxt.result = res;
				if (opc != crs_pkg::CRS_MOV || 1'b1) begin
					if (byte_op) begin
						if (dsel[2]) begin
							st_nxt.gen[dsel[1:0]][15:8] = res[7:0];
						end else begin
							st_nxt.gen[dsel[1:0]][7:0] = res[7:0];
						end
					end else begin
						st_nxt.gen[dsel] = res;
					end
				end
			end else if (da == crs_pkg::OFF_CTRL) begin
				// explicit control actions on the control flags
				if (wd[crs_pkg::CTRL_STEP_POS + 1]) begin
					st_nxt.flags[crs_pkg::STEP_POS] = wd[crs_pkg::CTRL_STEP_POS];
				end
				if (wd[crs_pkg::CTRL_INT_POS + 1]) begin
					st_nxt.flags[crs_pkg::IEN_POS] = wd[crs_pkg::CTRL_INT_POS];
				end
				if (wd[crs_pkg::CTRL_STR_POS + 1]) begin
					st_nxt.flags[crs_pkg::DIR_POS] = wd[crs_pkg::CTRL_STR_POS];
				end
				if (wd[crs_pkg::CTRL_STR_POS]) begin
					// string element step on the index register
					st_nxt.str_index = st_r.flags[crs_pkg::DIR_POS] ?
						st_r.gen[7] - 16'h0001 : st_r.gen[7] + 16'h0001;
					st_nxt.gen[7] = st_nxt.str_index;
				end
			end else if (da == crs_pkg::OFF_STEP) begin
				// instruction completes: ip advances by its length
				st_nxt.ip = st_r.ip + {12'h000, wd[3:0]};
				st_nxt.step_pend = st_r.flags[crs_pkg::STEP_POS];
			end else if (da == crs_pkg::OFF_ADDR) begin
				ssg = wd[1:0];
				// base reg 3, pointer 5, index 6, 7 chosen by mode bits
				unique case (wd[5:4])
					2'h0: off = st_r.gen[3] + st_r.gen[6];
					2'h1: off = st_r.gen[3] + st_r.gen[7];
					2'h2: off = st_r.gen[5] + st_r.gen[6];
					2'h3: off = st_r.gen[5] + st_r.gen[7];
				endcase
				off = off + hwdata[31:16];
				st_nxt.phys = {st_r.seg[ssg], {crs_pkg::SEG_SHIFT{1'b0}}}
					+ {4'h0, off};
			end
		end

		// pending single step fires after the completed instruction
		if (st_r.step_pend) begin
			st_nxt.step_trap = 1'b1;
			st_nxt.flags[crs_pkg::STEP_POS] = 1'b0;
		end

		// read data for the next data phase
		st_nxt.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			da = haddr[7:0];
			if (da < crs_pkg::OFF_SEG0) begin
				st_nxt.rdata = {16'h0000, st_nxt.gen[da[4:2]]};
			end else if (da < crs_pkg::OFF_IP) begin
				st_nxt.rdata = {16'h0000, st_nxt.seg[da[3:2]]};
			end else if (da == crs_pkg::OFF_IP) begin
				st_nxt.rdata = {16'h0000, st_nxt.ip};
			end else if (da == crs_pkg::OFF_FLAGS) begin
				st_nxt.rdata = {16'h0000, st_nxt.flags};
			end else if (da == crs_pkg::OFF_RES) begin
				st_nxt.rdata = {16'h0000, st_nxt.result};
			end else if (da == crs_pkg::OFF_ADDR) begin
				st_nxt.rdata = {12'h000, st_nxt.phys};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
			st_r.flags <= crs_pkg::FLAGS_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hrdata = st_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign int_taken = st_r.int_taken;
	assign step_trap = st_r.step_trap;
	assign proc_clk = st_r.proc_clk;

endmodule

`default_nettype wire

// ---- test/crs_regset_properties.sv ----
// crs_chk: port-level assertions for the register set block
// assumes it is bound into crs_regset, hready driven from hreadyout
`timescale 1ns/1ps
`default_nettype none
module crs_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic int_req,
	input wire logic int_taken,
	input wire logic step_trap,
	input wire logic proc_clk
);
	logic rd;
	assign rd = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////
	half_rate_a: assert property ($past(hresetn) |->
		proc_clk != $past(proc_clk)) else $error("clock toggle missed");
	step_once_a: assert property (step_trap |=> !step_trap)
		else $error("step trap repeated");
	int_once_a: assert property (int_taken |=> !int_taken)
		else $error("interrupt taken twice");
	int_gate_a: assert property (!int_req [*4] |=> !int_taken)
		else $error("interrupt without request");
	flag_fixed_a: assert property (rd && haddr[7:0] == 8'h34 |=>
		(hrdata & 32'hFFFF_F02A) == 32'h0000_F002) else $error("flags fixed");
	gen_width_a: assert property (rd && haddr[7:5] == 3'h0 |=>
		hrdata[31:16] == 16'h0) else $error("general reg width");
	seg_width_a: assert property (rd && haddr[7:4] == 4'h2 |=>
		hrdata[31:16] == 16'h0) else $error("segment width");
	phys_width_a: assert property (rd && haddr[7:0] == 8'h44 |=>
		hrdata[31:20] == 12'h0) else $error("address width");
	cover property (step_trap);
	cover property (int_taken);
	cover property (rd && haddr[7:0] == 8'h44);
endmodule
bind crs_regset crs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .int_req(int_req), .int_taken(int_taken),
	.step_trap(step_trap), .proc_clk(proc_clk));
`default_nettype wire

// ---- test/crs_regset_tb.sv ----
// crs_regset_tb: bus-level tests of the register set block
// assumes a zero-wait slave whose hreadyout feeds hready
`timescale 1ns/1ps
`default_nettype none
module crs_regset_tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic int_req = 1'b0;
	logic hready, hreadyout, hresp, int_taken, step_trap;
	int failures = 0, n_compared = 0, n_step = 0, n_int = 0, cycles = 0;
	// x, y, op command, expected reg 0, expected flags
	logic [79:0] tbl [11] = '{80'hFFFF_0001_0100_0000_F657,
		80'h7FFF_0001_0100_8000_FE96, 80'h0000_0001_0102_FFFF_F697,
		80'h0001_0001_0101_0003_F606, 80'h127F_0001_1100_1280_FE92,
		80'h00F0_000F_0104_0000_F646, 80'h0F00_00F0_0105_0FF0_F606,
		80'h8001_0001_0106_8000_F686, 80'h0001_0002_0102_FFFF_F697,
		80'h0005_0002_0103_0002_F602, 80'h0012_34CD_1147_CD12_F682};
	assign hready = hreadyout;
	always #10 hclk = ~hclk;
	crs_regset uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .int_req(int_req),
		.int_taken(int_taken), .step_trap(step_trap), .proc_clk());
	////////////////////////////////////////////////////////////////
	always @(posedge hclk) begin
		n_step <= n_step + (step_trap === 1'b1);
		n_int <= n_int + (int_taken === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("addr %h", a), q, e);
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic give_verdict;
		$display("compared %0d, failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(8'h34, 32'h0000_F002);
		for (int j = 0; j < 8; j++) begin
			wr(8'(4 * j), 32'hA5A5_0000 | j);
		end
		for (int j = 0; j < 8; j++) begin
			rc(8'(4 * j), 32'(j));
		end
		int_req <= 1'b1;
		repeat (8) @(posedge hclk);
		int_req <= 1'b0;
		repeat (4) @(posedge hclk);
		chk("masked interrupt", n_int, 0);
		done("registers and mask");
		wr(8'h40, 32'h0000_3300);
		wr(8'h1C, 32'h0000_0010);
		wr(8'h40, 32'h0000_0100);
		rc(8'h1C, 32'h0000_000F);
		wr(8'h40, 32'h0000_0200);
		wr(8'h40, 32'h0000_0100);
		wr(8'h40, 32'h0000_0100);
		rc(8'h1C, 32'h0000_0011);
		wr(8'h40, 32'h0000_0300);
		done("string direction");
		for (int i = 0; i < 11; i++) begin
			wr(8'h00, {16'h0, tbl[i][79:64]});
			wr(8'h04, {16'h0, tbl[i][63:48]});
			wr(8'h38, {16'h0, tbl[i][47:32]});
			rc(8'h00, {16'h0, tbl[i][31:16]});
			rc(8'h34, {16'h0, tbl[i][15:0]});
		end
		wr(8'h34, 32'h0000_FFFF);
		rc(8'h34, 32'h0000_FFD7);
		done("result flags");
		wr(8'h30, 32'h0000_0100);
		wr(8'h48, 32'h0000_0002);
		repeat (6) @(posedge hclk);
		chk("step trap", n_step, 1);
		rc(8'h30, 32'h0000_0102);
		rc(8'h34, 32'h0000_FED7);
		int_req <= 1'b1;
		repeat (6) @(posedge hclk);
		int_req <= 1'b0;
		repeat (4) @(posedge hclk);
		chk("interrupt", n_int, 1);
		rc(8'h34, 32'h0000_FCD7);
		done("trap and interrupt");
		wr(8'h20, 32'h0000_1234);
		wr(8'h24, 32'h0000_FFFF);
		for (int j = 3; j < 8; j++) begin
			wr(8'(4 * j), 32'h0);
		end
		wr(8'h44, 32'h0010_0000);
		rc(8'h44, 32'h0001_2350);
		wr(8'h44, 32'h0020_0001);
		rc(8'h44, 32'h0000_0010);
		wr(8'h14, 32'h0000_0100);
		wr(8'h1C, 32'h0000_0020);
		wr(8'h44, 32'h0004_0030);
		rc(8'h44, 32'h0001_2464);
		wr(8'h4C, 32'h0000_AB04);
		rc(8'h00, 32'h0000_AB12);
		chk("response", {31'h0, hresp}, 32'h0);
		wr(8'h80, 32'hFFFF_FFFF);
		rc(8'h80, 32'h0000_0000);
		done("addressing");
		give_verdict();
	end
endmodule
`default_nettype wire
